// file: rtl/acv_top.sv
// module: converter control registers on an Avalon-MM slave
`timescale 1ns/1ns
// Contract
// - control bit 7 switches converter on, resets off
// - writing 1 to bit 6 with bit 7 set starts one conversion when idle on a defined channel
// - bit 6 reads 1 when ready or done
// - bits 5:2 pick pin 0-12 or internal F
// - channel F is band-gap or quarter supply
// - mode bits 3:1 divide clock by 2**code
// - reference bits 7:5 choose high reference source
// - reference bit 4 routes quarter supply to F
// - reference bits 3:2 set band-gap level on F
// - high result holds result bits 11 to 4
// - low result bits 7:4 hold result 3:0
module acv_top
    import acv_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic conv_enable,
    output logic conv_start,
    output logic conv_clk_en,
    output logic [CH_W-1:0] conv_channel,
    output logic conv_chf_sel,
    output logic conv_ch_reserved,
    output logic conv_chf_quarter,
    output logic [REF_BG_W-1:0] conv_bg_level,
    output logic [REF_HI_W-1:0] conv_refhi_sel,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_result
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [REG_W-1:0] rdata;
        logic en;
        logic [CH_W-1:0] ch;
        logic ch_int;
        logic ch_bad;
        logic [DIV_W-1:0] div;
        logic [REF_HI_W-1:0] refhi;
        logic chfq;
        logic [REF_BG_W-1:0] bg;
        logic go;
        logic [EV_W-1:0] sts;
        logic [EV_W-1:0] msk;
    } acv_top_s;

    acv_top_s r;
    acv_top_s next_r;

    acv_conv_if #(.W(RES_W)) cif ();

    logic [7:0] idx;
    logic req;
    logic take;
    logic wr_take;
    logic [REG_W-1:0] wd;
    logic ready_rd;
    logic [REG_W-1:0] rmux;
    logic start_try;
    logic start_ok;
    logic [CH_W-1:0] ch_new;
    logic new_bad;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] w1c;
    logic tick;

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    // converter clock tick from the mode divider
    acv_clkdiv #(.SEL_W(DIV_W)) u_div (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .div_sel(r.div),
        .tick(tick)
    );

    // conversion sequencer owns the busy flag and result
    acv_seq #(.W(RES_W)) u_seq (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .cif(cif.seq),
        .enable(r.en),
        .tick(tick),
        .core_start(conv_start),
        .core_done(conv_done),
        .core_result(conv_result)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait state: first cycle captures, second cycle answers
    assign idx = avs_address[ADDR_W-1:IDX_LSB];
    assign req = avs_read || avs_write;
    assign take = req && r.ack;
    assign wr_take = take && avs_write && avs_byteenable[0];
    assign wd = avs_writedata[REG_W-1:0];
    assign avs_waitrequest = req && !r.ack;

    // a start still in flight reads as busy, so a poll right after
    // the start write cannot see a stale ready
    assign ready_rd = cif.ready && !r.go;
    assign cif.go = r.go;

    // read mux; reserved and write-only bits read zero
    always_comb begin
        rmux = '0;
        case (idx)
            IDX_CTRL: begin
                rmux[CTRL_EN_BIT] = r.en;
                rmux[CTRL_GO_BIT] = ready_rd;
                rmux[CTRL_CH_LSB +: CH_W] = r.ch;
            end
            IDX_MODE: rmux[MODE_DIV_LSB +: DIV_W] = r.div;
            IDX_RES_HI: rmux = cif.result[RES_W-1 -: REG_W];
            IDX_RES_LO: rmux[REG_W-1 -: RES_LO_W] = cif.result[RES_LO_W-1:0];
            IDX_STS: rmux[EV_W-1:0] = r.sts;
            IDX_MSK: rmux[EV_W-1:0] = r.msk;
            default: rmux = '0;
        endcase
    end

    // ------------------------------------------------------------
    // start and events
    // ------------------------------------------------------------
    // a start needs the converter on, idle and a defined channel
    assign start_try = wr_take && idx == IDX_CTRL && wd[CTRL_GO_BIT];
    assign ch_new = wd[CTRL_CH_LSB +: CH_W];
    assign new_bad = (ch_new > CH_LAST_PIN) && (ch_new != CH_INTERNAL);
    assign start_ok = start_try && wd[CTRL_EN_BIT] && ready_rd && !new_bad;

    // event sources for the sticky status
    always_comb begin
        ev = '0;
        ev[EV_DONE] = cif.done_evt;
        ev[EV_REFUSED] = start_try && !start_ok;
    end

    // write-one-to-clear mask from a status write
    assign w1c = (wr_take && idx == IDX_STS) ? wd[EV_W-1:0] : '0;

    // ------------------------------------------------------------
    // register next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        // handshake: capture read data on the first cycle
        next_r.ack = req && !r.ack;
        if (req && !r.ack) begin
            next_r.rdata = rmux;
        end
        // start request lives one cycle, the sequencer picks it up
        next_r.go = start_ok;
        // set wins over clear in the same cycle
        next_r.sts = (r.sts & ~w1c) | ev;
        if (wr_take) begin
            case (idx)
                IDX_CTRL: begin
                    // bits 1:0 are ignored on write
                    next_r.en = wd[CTRL_EN_BIT];
                    next_r.ch = ch_new;
                    next_r.ch_int = (ch_new == CH_INTERNAL);
                    next_r.ch_bad = new_bad;
                end
                IDX_MODE: next_r.div = wd[MODE_DIV_LSB +: DIV_W];
                IDX_REF: begin
                    next_r.refhi = wd[REF_HI_LSB +: REF_HI_W];
                    next_r.chfq = wd[REF_CHF_BIT];
                    next_r.bg = wd[REF_BG_LSB +: REF_BG_W];
                end
                IDX_MSK: next_r.msk = wd[EV_W-1:0];
                default: next_r.msk = r.msk;
            endcase
        end
    end

    // all registers clear at reset; ce freezes everything
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // upper lanes carry no register bits
    assign avs_readdata = {{(DATA_W - REG_W){1'b0}}, r.rdata};
    assign irq = |(r.sts & r.msk);
    assign conv_enable = r.en;
    // gated by ce: a counter frozen at its terminal count would tick every cycle
    assign conv_clk_en = tick && r.en && ce;
    assign conv_channel = r.ch;
    assign conv_chf_sel = r.ch_int;
    assign conv_ch_reserved = r.ch_bad;
    assign conv_chf_quarter = r.chfq;
    assign conv_bg_level = r.bg;
    assign conv_refhi_sel = r.refhi;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    wait_one_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && req && avs_waitrequest) ##1 req |-> !avs_waitrequest)
        else $error("waitrequest held past one cycle");

    enable_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && wr_take && idx == IDX_CTRL) |=> conv_enable == $past(wd[CTRL_EN_BIT]))
        else $error("enable bit not applied");

    start_busy_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && start_ok) ##1 ce |=> (!cif.ready && conv_start))
        else $error("accepted start did not begin a conversion");

    ready_read_a: assert property (@(posedge core_clk) disable iff (rst)
        (take && avs_read && idx == IDX_CTRL && $past(ce))
            |-> avs_readdata[CTRL_GO_BIT] == $past(ready_rd))
        else $error("ready bit read back wrong");

    channel_f_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && wr_take && idx == IDX_CTRL && ch_new == CH_INTERNAL)
            |=> (conv_chf_sel && !conv_ch_reserved && conv_channel == CH_INTERNAL))
        else $error("internal channel code not decoded");

    ref_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && wr_take && idx == IDX_REF)
            |=> (conv_refhi_sel == $past(wd[REF_HI_LSB +: REF_HI_W])
                && conv_chf_quarter == $past(wd[REF_CHF_BIT])
                && conv_bg_level == $past(wd[REF_BG_LSB +: REF_BG_W])))
        else $error("reference fields not applied");

    result_high_a: assert property (@(posedge core_clk) disable iff (rst)
        (take && avs_read && idx == IDX_RES_HI && $past(ce))
            |-> avs_readdata[REG_W-1:0] == $past(cif.result[RES_W-1 -: REG_W]))
        else $error("high result misplaced");

    result_low_a: assert property (@(posedge core_clk) disable iff (rst)
        (take && avs_read && idx == IDX_RES_LO && $past(ce))
            |-> (avs_readdata[REG_W-1 -: RES_LO_W] == $past(cif.result[RES_LO_W-1:0])
                && avs_readdata[RES_LO_W-1:0] == '0))
        else $error("low result misplaced");

    busy_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        (take && avs_read && idx == IDX_CTRL && $past(ce) && $past(r.go))
            |-> !avs_readdata[CTRL_GO_BIT])
        else $error("flag read high with a start in flight");

    done_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && cif.done_evt) |=> r.sts[EV_DONE] ##1 (r.sts[EV_DONE] || !$past(ce) || $past(w1c[EV_DONE])))
        else $error("done event not held in status");

    refuse_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && start_try && !wd[CTRL_EN_BIT]) |=> (r.sts[EV_REFUSED] && !r.go))
        else $error("start while off not refused");
endmodule // acv_top

// file: rtl/acv_pkg.sv
// package: shared constants and types of the converter control block
package acv_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int RES_W = 12;
    localparam int CH_W = 4;
    localparam int DIV_W = 3;
    localparam int REF_HI_W = 3;
    localparam int REF_BG_W = 2;
    localparam int IDX_LSB = 2;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h20;
    localparam logic [7:0] IDX_MODE = 8'h21;
    localparam logic [7:0] IDX_RES_HI = 8'h22;
    localparam logic [7:0] IDX_RES_LO = 8'h23;
    localparam logic [7:0] IDX_REF = 8'h24;
    localparam logic [7:0] IDX_STS = 8'h28;
    localparam logic [7:0] IDX_MSK = 8'h29;
    // field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_GO_BIT = 6;
    localparam int CTRL_CH_LSB = 2;
    localparam int MODE_DIV_LSB = 1;
    localparam int REF_HI_LSB = 5;
    localparam int REF_CHF_BIT = 4;
    localparam int REF_BG_LSB = 2;
    localparam int RES_LO_W = 4;
    localparam logic [CH_W-1:0] CH_LAST_PIN = 4'hC;
    localparam logic [CH_W-1:0] CH_INTERNAL = 4'hF;
    // event bits of status and mask
    localparam int EV_W = 2;
    localparam int EV_DONE = 0;
    localparam int EV_REFUSED = 1;
    // sequencer states, gray along idle-start-wait-load
    typedef enum logic [1:0] {
        ACV_IDLE = 2'h0,
        ACV_START = 2'h1,
        ACV_WAIT = 2'h3,
        ACV_LOAD = 2'h2
    } acv_state_e;
endpackage

// file: rtl/acv_conv_if.sv
// interface: start request and result path between register front and sequencer
`timescale 1ns/1ns
interface acv_conv_if #(parameter int W = 12);
    logic go;
    logic ready;
    logic done_evt;
    logic [W-1:0] result;
    modport front (output go, input ready, input done_evt, input result);
    modport seq (input go, output ready, output done_evt, output result);
endinterface

// file: rtl/acv_clkdiv.sv
// module: power-of-two divider giving the converter clock tick
`timescale 1ns/1ns
module acv_clkdiv
    import acv_pkg::*;
#(
    parameter int SEL_W = DIV_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [SEL_W-1:0] div_sel,
    output logic tick
);
    localparam int CNT_W = (1 << SEL_W) - 1;
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } acv_div_s;
    acv_div_s r;
    acv_div_s next_r;
    logic [CNT_W-1:0] limit;

    // terminal count is 2**code - 1: bit i set while i is below the code
    for (genvar i = 0; i < CNT_W; i++) begin : g_lim
        assign limit[i] = (i < int'(div_sel));
    end

    // >= so a smaller code mid-count cannot run the counter round once
    assign tick = (r.cnt >= limit);

    // counter next value
    always_comb begin
        next_r = r;
        next_r.cnt = tick ? '0 : r.cnt + 1'b1;
    end

    // state register, frozen while ce is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    div_gap_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && tick && div_sel != '0 && r.cnt == limit) ##1 (ce && $stable(div_sel)) |-> !tick)
        else $error("divided clock ticked on two cycles in a row");
endmodule // acv_clkdiv

// file: rtl/acv_seq.sv
// module: conversion sequencer between register front and analog core
`timescale 1ns/1ns
module acv_seq
    import acv_pkg::*;
#(
    parameter int W = RES_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    acv_conv_if.seq cif,
    input wire logic enable,
    input wire logic tick,
    output logic core_start,
    input wire logic core_done,
    input wire logic [W-1:0] core_result
);
    typedef struct packed {
        acv_state_e st;
        logic [W-1:0] result;
    } acv_seq_s;
    acv_seq_s r;
    acv_seq_s next_r;

    // sequence: hold start until a converter tick, wait for done, load
    always_comb begin
        next_r = r;
        case (r.st)
            ACV_IDLE: if (cif.go && enable) next_r.st = ACV_START;
            ACV_START: begin
                // switching the converter off aborts; old result stays
                if (!enable) next_r.st = ACV_IDLE;
                else if (tick) next_r.st = ACV_WAIT;
            end
            ACV_WAIT: begin
                if (!enable) begin
                    next_r.st = ACV_IDLE;
                end else if (core_done) begin
                    next_r.result = core_result;
                    next_r.st = ACV_LOAD;
                end
            end
            ACV_LOAD: next_r.st = ACV_IDLE;
            default: next_r.st = ACV_IDLE;
        endcase
    end

    // state register, frozen while ce is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '{st: ACV_IDLE, result: '0};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign core_start = (r.st == ACV_START);
    assign cif.ready = (r.st == ACV_IDLE);
    assign cif.done_evt = (r.st == ACV_LOAD);
    assign cif.result = r.result;

    result_load_a: assert property (@(posedge core_clk) disable iff (rst)
        (ce && r.st == ACV_WAIT && enable && core_done)
            |=> (cif.result == $past(core_result) && !cif.ready) ##1 (cif.ready || !$past(ce)))
        else $error("result not loaded or flag early");
endmodule // acv_seq

// file: sim/acv_core_model.sv
// partner model: analog converter core answering start requests after a tick count
`timescale 1ns/1ns
module acv_core_model
    import acv_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic conv_start,
    input wire logic conv_clk_en,
    input wire logic [CH_W-1:0] conv_channel,
    input wire logic [7:0] ticks,
    output logic conv_done,
    output logic [RES_W-1:0] conv_result
);
    logic busy;
    logic [7:0] cnt;
    logic [CH_W-1:0] ch;
    // --------------------------------------------------------------
    // conversion timing
    // --------------------------------------------------------------
    // pins are analog only here, no digital input path
    // result toggles outside the done cycle so a stale capture shows up
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            ch <= 4'h0;
            conv_done <= 1'b0;
            conv_result <= 12'h5A5;
        end else begin
            conv_done <= 1'b0;
            conv_result <= ~conv_result;
            if (busy && conv_clk_en) begin
                cnt <= cnt - 8'h01;
                if (cnt == 8'h00) begin
                    busy <= 1'b0;
                    conv_done <= 1'b1;
                    conv_result <= {ch, ~ch, ch ^ 4'h9};
                end
            end else if (!busy && conv_start && conv_clk_en) begin
                busy <= 1'b1;
                cnt <= ticks;
                ch <= conv_channel;
            end
        end
    end
endmodule // acv_core_model

// file: sim/tb_top.sv
// testbench: register-level tests of the converter control block
`timescale 1ns/1ns
module tb_top
    import acv_pkg::*;
;
    localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] A_MODE = {IDX_MODE, 2'b00};
    localparam logic [9:0] A_HI = {IDX_RES_HI, 2'b00};
    localparam logic [9:0] A_LO = {IDX_RES_LO, 2'b00};
    localparam logic [9:0] A_REF = {IDX_REF, 2'b00};
    localparam logic [9:0] A_STS = {IDX_STS, 2'b00};
    localparam logic [9:0] A_MSK = {IDX_MSK, 2'b00};
    logic core_clk, rst, ce, avs_read, avs_write, avs_waitrequest, irq;
    logic [9:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic conv_enable, conv_start, conv_clk_en, conv_chf_sel, conv_ch_reserved;
    logic conv_chf_quarter, conv_done;
    logic [3:0] conv_channel;
    logic [1:0] conv_bg_level;
    logic [2:0] conv_refhi_sel;
    logic [11:0] conv_result;
    logic [7:0] ticks, d;
    logic [3:0] chans [4] = '{4'h0, 4'h5, 4'hC, 4'hF};
    int failures = 0;
    int samples_checked = 0;
    int n;

    acv_top u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .conv_enable(conv_enable),
        .conv_start(conv_start), .conv_clk_en(conv_clk_en), .conv_channel(conv_channel),
        .conv_chf_sel(conv_chf_sel), .conv_ch_reserved(conv_ch_reserved),
        .conv_chf_quarter(conv_chf_quarter), .conv_bg_level(conv_bg_level),
        .conv_refhi_sel(conv_refhi_sel), .conv_done(conv_done), .conv_result(conv_result));
    acv_core_model u_model (.core_clk(core_clk), .rst(rst), .conv_start(conv_start),
        .conv_clk_en(conv_clk_en), .conv_channel(conv_channel), .ticks(ticks),
        .conv_done(conv_done), .conv_result(conv_result));

    // --------------------------------------------------------------
    // clock, watchdog and verdict
    // --------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // whole run needs about 1700 cycles; a hang is cut well after that
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        close_out();
    end
    task automatic close_out();
        $display("counts: %0d mismatches in %0d checks", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // bus tasks: request held until waitrequest is sampled low
    // --------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_access(input logic wr, input logic [9:0] a, input logic [7:0] wd);
        avs_address <= a;
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        // no local limit: the watchdog ends a hung handshake
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic bus_write(input logic [9:0] a, input logic [7:0] wd);
        bus_access(1'b1, a, wd);
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
        bus_access(1'b0, a, 8'h00);
        chk(what, exp, d);
    endtask
    // start, poll to completion, then check both result halves
    task automatic convert(input logic [3:0] c);
        logic [11:0] r;
        int k;
        r = {c, ~c, c ^ 4'h9};
        bus_write(A_STS, 8'h03);
        bus_write(A_CTRL, {2'b11, c, 2'b00});
        rd_chk(A_CTRL, {2'b10, c, 2'b00}, "busy flag");
        k = 0;
        while (d[6] !== 1'b1 && k < 200) begin
            bus_access(1'b0, A_CTRL, 8'h00);
            k++;
        end
        chk("ready flag", 8'h01, {7'h0, d[6]});
        rd_chk(A_HI, r[11:4], "result high");
        rd_chk(A_LO, {r[3:0], 4'h0}, "result low");
        rd_chk(A_STS, 8'h01, "done status");
    endtask

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        ticks = 8'd3;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // reset values of control, mode and both result registers and an unmapped place
        rd_chk(A_CTRL, 8'h40, "ctrl reset");
        rd_chk(A_MODE, 8'h00, "mode reset");
        rd_chk(A_HI, 8'h00, "high reset");
        rd_chk(A_LO, 8'h00, "low reset");
        bus_write(10'h3FC, 8'hFF);
        rd_chk(10'h3FC, 8'h00, "unmapped");
        chk("enable out", 8'h00, {7'h0, conv_enable});
        $display("test reset done");
        // divider: tick count over a 128-cycle window for every code
        bus_write(A_CTRL, 8'h80);
        for (int k = 0; k < 8; k++) begin
            bus_write(A_MODE, 8'(k << 1));
            rd_chk(A_MODE, 8'(k << 1), "mode");
            n = 0;
            repeat (128) begin
                @(posedge core_clk);
                if (conv_clk_en === 1'b1) n++;
            end
            chk("tick count", 8'(128 >> k), n[7:0]);
        end
        // ce low freezes the divider: no converter tick may leak out
        ce <= 1'b0;
        n = 0;
        repeat (64) begin
            @(posedge core_clk);
            if (conv_clk_en === 1'b1) n++;
        end
        ce <= 1'b1;
        chk("frozen ticks", 8'h00, n[7:0]);
        rd_chk(A_MODE, 8'h0E, "mode after freeze");
        $display("test divider done");
        // reference fields reach the core, register reads back zero
        for (int k = 0; k < 8; k++) begin
            bus_write(A_REF, {k[2:0], k[0], k[1:0], 2'b00});
            chk("refhi", 8'(k), {5'h0, conv_refhi_sel});
            chk("chf quarter", {7'h0, k[0]}, {7'h0, conv_chf_quarter});
            chk("bg level", {6'h0, k[1:0]}, {6'h0, conv_bg_level});
        end
        rd_chk(A_REF, 8'h00, "ref read");
        $display("test reference done");
        // every channel code, reserved ones included
        for (int c = 0; c < 16; c++) begin
            bus_write(A_CTRL, 8'h80 | 8'(c << 2));
            rd_chk(A_CTRL, 8'hC0 | 8'(c << 2), "ctrl channel");
            chk("channel", 8'(c), {4'h0, conv_channel});
            chk("chf sel", 8'(c == 15), {7'h0, conv_chf_sel});
            chk("ch reserved", 8'(c == 13 || c == 14), {7'h0, conv_ch_reserved});
        end
        $display("test channels done");
        // conversions, core answering promptly and slowly in turn
        bus_write(A_MODE, 8'h02);
        foreach (chans[i]) begin
            ticks <= (i % 2 == 1) ? 8'd20 : 8'd3;
            convert(chans[i]);
        end
        chk("irq masked", 8'h00, {7'h0, irq});
        bus_write(A_MSK, 8'h03);
        chk("irq raised", 8'h01, {7'h0, irq});
        bus_write(A_STS, 8'h01);
        chk("irq cleared", 8'h00, {7'h0, irq});
        $display("test conversion done");
        // refused starts leave the old result in place
        bus_write(A_CTRL, 8'h40);
        rd_chk(A_STS, 8'h02, "refused off");
        chk("irq refused", 8'h01, {7'h0, irq});
        bus_write(A_STS, 8'h02);
        bus_write(A_CTRL, 8'hF4);
        rd_chk(A_STS, 8'h02, "refused reserved");
        rd_chk(A_CTRL, 8'hF4, "ctrl after refuse");
        rd_chk(A_HI, 8'hF0, "result kept");
        avs_byteenable <= 4'hE;
        bus_write(A_MSK, 8'h00);
        avs_byteenable <= 4'hF;
        rd_chk(A_MSK, 8'h03, "mask byte lane");
        $display("test refusal done");
        // abort with the start still pending: no done event, result kept
        // slowest divider keeps the start pending long enough to see it
        bus_write(A_MODE, 8'h0E);
        bus_write(A_STS, 8'h03);
        ticks <= 8'd20;
        bus_write(A_CTRL, 8'hD4);
        @(posedge core_clk);
        chk("start out", 8'h01, {7'h0, conv_start});
        bus_write(A_CTRL, 8'hD4);
        rd_chk(A_STS, 8'h02, "refused busy");
        bus_write(A_CTRL, 8'h14);
        @(posedge core_clk);
        chk("start dropped", 8'h00, {7'h0, conv_start});
        repeat (100) @(posedge core_clk);
        rd_chk(A_CTRL, 8'h54, "ctrl after abort");
        rd_chk(A_STS, 8'h02, "no done event");
        rd_chk(A_LO, 8'h60, "low kept");
        $display("test abort done");
        close_out();
    end
endmodule // tb_top
